// ---- common/ifs_pkg.sv ----
// package: offsets, masks and carrier types for the interrupt flag block
package ifs_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    // register indices (word offsets)
    localparam logic [3:0] OFF_FLAGS_LOW = 4'h0;
    localparam logic [3:0] OFF_FLAGS_HIGH = 4'h1;
    localparam logic [3:0] OFF_PEND_STAT = 4'h2;
    localparam logic [3:0] OFF_PEND_MASK = 4'h3;
    // implemented bit masks
    localparam logic [15:0] LOW_IMPL_MASK = 16'h7fef;
    localparam logic [15:0] HIGH_IMPL_MASK = 16'he87f;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [1:0] STAT_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;
    // status bit positions
    localparam int STAT_LOW_POS = 0;
    localparam int STAT_HIGH_POS = 1;
    // flag positions, low register
    localparam int POS_TWOWIRE_MASTER = 14;
    localparam int POS_TWOWIRE_SLAVE = 13;
    localparam int POS_NONVOLATILE = 12;
    localparam int POS_CONVERSION_DONE = 11;
    localparam int POS_SERIAL_TX = 10;
    localparam int POS_SERIAL_RX = 9;
    localparam int POS_SYNC_SERIAL = 8;
    localparam int POS_THIRD_TIMER = 7;
    localparam int POS_SECOND_TIMER = 6;
    localparam int POS_COMPARE_TWO = 5;
    localparam int POS_FIRST_TIMER = 3;
    localparam int POS_COMPARE_ONE = 2;
    localparam int POS_CAPTURE_ONE = 1;
    localparam int POS_EXT_PIN_ZERO = 0;
    // flag positions, high register
    localparam int POS_COMPARATOR_THREE = 15;
    localparam int POS_COMPARATOR_TWO = 14;
    localparam int POS_COMPARATOR_ONE = 13;
    localparam int POS_CHANGE_NOTIFY = 11;
    localparam int POS_PULSE_GEN_FOUR = 6;
    localparam int POS_PULSE_GEN_THREE = 5;
    localparam int POS_PULSE_GEN_TWO = 4;
    localparam int POS_PULSE_GEN_ONE = 3;
    localparam int POS_SPECIAL_EVENT = 2;
    localparam int POS_EXT_PIN_TWO = 1;
    localparam int POS_EXT_PIN_ONE = 0;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ifs_bus_req_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACCESS = 2'b10
    } ifs_bus_state_t;
endpackage : ifs_pkg

// ---- verilog/ifs_flag_reg.sv ----
// one 16-bit flag register: sticky set, software write, unimplemented bits zero
`timescale 1ns/100ps
`default_nettype none
module ifs_flag_reg #(
    parameter logic [15:0] IMPL_MASK = 16'hffff
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] event_in,
    input wire logic wr_en,
    input wire logic [15:0] wdata,
    output logic [15:0] flags,
    output logic [15:0] new_events
);
    logic [15:0] flags_reg;
    logic [15:0] flags_next;

    always_comb begin
        flags_next = flags_reg;
        // R03: software write path
        if (wr_en) begin
            flags_next = wdata;
        end
        // R18: event wins over clear
        flags_next = flags_next | event_in;
        // R02: unimplemented bits zero
        flags_next = flags_next & IMPL_MASK;
    end

    // R03: cleared at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg <= ifs_pkg::FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;
    assign new_events = event_in & IMPL_MASK;
endmodule // ifs_flag_reg

`default_nettype wire

// ---- verilog/ifs_interrupt_flags.sv ----
// interrupt flag status registers with pending summary and interrupt output
//
// Functional notes
// R01: implemented flag reads 1 while its source request is pending, else 0.
// R02: unimplemented positions ignore writes and read zero in both registers.
// R03: implemented flags read/write by software, zero after reset.
// R04: low register bit 14 latches two-wire master events.
// R05: low register bit 13 latches two-wire slave events.
// R06: low register bit 12 latches nonvolatile memory requests.
// R07: low register bit 11 sets on conversion complete.
// R08: low register bit 10 latches serial transmitter requests.
// R09: low register bit 9 latches serial receiver requests.
// R10: low register bit 8 latches synchronous serial events.
// R11: low register bits 7 and 6 latch third and second timer.
// R12: low register bit 5 latches compare channel two.
// R13: low register bit 3 latches first timer.
// R14: low register bits 2 and 1 latch compare one, capture one.
// R15: low register bit 0 latches external pin zero.
// R16: high bits 15..13 comparators three..one; bit 11 change notify.
// R17: high bits 6..3 pulse generators four..one.
// R18: flag sticky until software writes 0; event beats clear.
// R19: high bit 2 special event; bits 1, 0 external pins two, one.
`timescale 1ns/100ps
`default_nettype none
module ifs_interrupt_flags (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic TWOWIRE_MASTER_EV,
    input wire logic TWOWIRE_SLAVE_EV,
    input wire logic NONVOLATILE_EV,
    input wire logic CONVERSION_DONE_EV,
    input wire logic SERIAL_TX_EV,
    input wire logic SERIAL_RX_EV,
    input wire logic SYNC_SERIAL_EV,
    input wire logic THIRD_TIMER_EV,
    input wire logic SECOND_TIMER_EV,
    input wire logic COMPARE_TWO_EV,
    input wire logic FIRST_TIMER_EV,
    input wire logic COMPARE_ONE_EV,
    input wire logic CAPTURE_ONE_EV,
    input wire logic EXT_PIN_ZERO_EV,
    input wire logic COMPARATOR_THREE_EV,
    input wire logic COMPARATOR_TWO_EV,
    input wire logic COMPARATOR_ONE_EV,
    input wire logic CHANGE_NOTIFY_EV,
    input wire logic PULSE_GEN_FOUR_EV,
    input wire logic PULSE_GEN_THREE_EV,
    input wire logic PULSE_GEN_TWO_EV,
    input wire logic PULSE_GEN_ONE_EV,
    input wire logic SPECIAL_EVENT_EV,
    input wire logic EXT_PIN_TWO_EV,
    input wire logic EXT_PIN_ONE_EV,
    output logic [15:0] RDATA,
    output logic [15:0] FLAGS_LOW,
    output logic [15:0] FLAGS_HIGH,
    output logic IRQ
);
    ifs_pkg::ifs_bus_req_t req;
    logic [15:0] ev_low;
    logic [15:0] ev_high;
    logic [15:0] low_flags;
    logic [15:0] high_flags;
    logic [15:0] low_new;
    logic [15:0] high_new;
    logic wr_low;
    logic wr_high;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic [1:0] stat_reg;
    logic [1:0] stat_next;
    logic [1:0] mask_reg;
    logic [1:0] mask_next;
    logic irq_reg;
    logic irq_next;
    logic [15:0] out_low_reg;
    logic [15:0] out_high_reg;
    ifs_pkg::ifs_bus_state_t bus_state_reg;
    ifs_pkg::ifs_bus_state_t bus_state_next;
    logic [15:0] wdata_low;
    logic [15:0] wdata_high;
    logic rd_low;
    logic rd_high;
    logic rd_stat;
    logic rd_mask;
    logic wr_mask;
    logic low_any;
    logic high_any;
    logic [1:0] pend_unmasked;
    logic [15:0] out_low_next;
    logic [15:0] out_high_next;

    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    // source mapping for the low register
    always_comb begin
        ev_low = 16'h0000;
        // R04: two-wire master
        ev_low[ifs_pkg::POS_TWOWIRE_MASTER] = TWOWIRE_MASTER_EV;
        // R05: two-wire slave
        ev_low[ifs_pkg::POS_TWOWIRE_SLAVE] = TWOWIRE_SLAVE_EV;
        // R06: nonvolatile memory
        ev_low[ifs_pkg::POS_NONVOLATILE] = NONVOLATILE_EV;
        // R07: conversion complete
        ev_low[ifs_pkg::POS_CONVERSION_DONE] = CONVERSION_DONE_EV;
        // R08: serial transmitter
        ev_low[ifs_pkg::POS_SERIAL_TX] = SERIAL_TX_EV;
        // R09: serial receiver
        ev_low[ifs_pkg::POS_SERIAL_RX] = SERIAL_RX_EV;
        // R10: synchronous serial port
        ev_low[ifs_pkg::POS_SYNC_SERIAL] = SYNC_SERIAL_EV;
        // R11: third, second timer
        ev_low[ifs_pkg::POS_THIRD_TIMER] = THIRD_TIMER_EV;
        ev_low[ifs_pkg::POS_SECOND_TIMER] = SECOND_TIMER_EV;
        // R12: compare channel two
        ev_low[ifs_pkg::POS_COMPARE_TWO] = COMPARE_TWO_EV;
        // R13: first timer
        ev_low[ifs_pkg::POS_FIRST_TIMER] = FIRST_TIMER_EV;
        // R14: compare one, capture one
        ev_low[ifs_pkg::POS_COMPARE_ONE] = COMPARE_ONE_EV;
        ev_low[ifs_pkg::POS_CAPTURE_ONE] = CAPTURE_ONE_EV;
        // R15: external pin zero
        ev_low[ifs_pkg::POS_EXT_PIN_ZERO] = EXT_PIN_ZERO_EV;
    end

    // source mapping for the high register
    always_comb begin
        ev_high = 16'h0000;
        // R16: comparators and change notify
        ev_high[ifs_pkg::POS_COMPARATOR_THREE] = COMPARATOR_THREE_EV;
        ev_high[ifs_pkg::POS_COMPARATOR_TWO] = COMPARATOR_TWO_EV;
        ev_high[ifs_pkg::POS_COMPARATOR_ONE] = COMPARATOR_ONE_EV;
        ev_high[ifs_pkg::POS_CHANGE_NOTIFY] = CHANGE_NOTIFY_EV;
        // R17: pulse generators
        ev_high[ifs_pkg::POS_PULSE_GEN_FOUR] = PULSE_GEN_FOUR_EV;
        ev_high[ifs_pkg::POS_PULSE_GEN_THREE] = PULSE_GEN_THREE_EV;
        ev_high[ifs_pkg::POS_PULSE_GEN_TWO] = PULSE_GEN_TWO_EV;
        ev_high[ifs_pkg::POS_PULSE_GEN_ONE] = PULSE_GEN_ONE_EV;
        // R19: special event, external pins
        ev_high[ifs_pkg::POS_SPECIAL_EVENT] = SPECIAL_EVENT_EV;
        ev_high[ifs_pkg::POS_EXT_PIN_TWO] = EXT_PIN_TWO_EV;
        ev_high[ifs_pkg::POS_EXT_PIN_ONE] = EXT_PIN_ONE_EV;
    end

    // write decode: one target per strobe, index 2 is read-only
    always_comb begin
        wr_low = 1'b0;
        wr_high = 1'b0;
        wr_mask = 1'b0;
        if (req.wr && req.addr == ifs_pkg::OFF_FLAGS_LOW) begin
            wr_low = 1'b1;
        end else if (req.wr && req.addr == ifs_pkg::OFF_FLAGS_HIGH) begin
            wr_high = 1'b1;
        end else if (req.wr && req.addr == ifs_pkg::OFF_PEND_MASK) begin
            wr_mask = 1'b1;
        end
    end

    // read decode: unmapped indices select nothing and read zero
    always_comb begin
        rd_low = 1'b0;
        rd_high = 1'b0;
        rd_stat = 1'b0;
        rd_mask = 1'b0;
        if (req.rd && req.addr == ifs_pkg::OFF_FLAGS_LOW) begin
            rd_low = 1'b1;
        end else if (req.rd && req.addr == ifs_pkg::OFF_FLAGS_HIGH) begin
            rd_high = 1'b1;
        end else if (req.rd && req.addr == ifs_pkg::OFF_PEND_STAT) begin
            rd_stat = 1'b1;
        end else if (req.rd && req.addr == ifs_pkg::OFF_PEND_MASK) begin
            rd_mask = 1'b1;
        end
    end

    // R02: unimplemented positions drop written ones at entry
    always_comb begin
        wdata_low = req.wdata & ifs_pkg::LOW_IMPL_MASK;
        wdata_high = req.wdata & ifs_pkg::HIGH_IMPL_MASK;
    end

    // R01: low flag register
    ifs_flag_reg #(
        .IMPL_MASK(ifs_pkg::LOW_IMPL_MASK)
    ) u_flags_low (
        .clk(MCLK),
        .rst_n(NRST),
        .event_in(ev_low),
        .wr_en(wr_low),
        .wdata(wdata_low),
        .flags(low_flags),
        .new_events(low_new)
    );

    // R01: high flag register
    ifs_flag_reg #(
        .IMPL_MASK(ifs_pkg::HIGH_IMPL_MASK)
    ) u_flags_high (
        .clk(MCLK),
        .rst_n(NRST),
        .event_in(ev_high),
        .wr_en(wr_high),
        .wdata(wdata_high),
        .flags(high_flags),
        .new_events(high_new)
    );

    // access tracker: marks the cycle in which read data stand
    always_comb begin
        bus_state_next = ifs_pkg::BUS_IDLE;
        if (req.rd) begin
            bus_state_next = ifs_pkg::BUS_ACCESS;
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            bus_state_reg <= ifs_pkg::BUS_IDLE;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    // R01: read data stand one cycle after the strobe, then expire
    always_comb begin
        rdata_next = rdata_reg;
        if (bus_state_reg == ifs_pkg::BUS_ACCESS || req.rd) begin
            rdata_next = 16'h0000;
        end
        if (rd_low) begin
            rdata_next = low_flags;
        end else if (rd_high) begin
            rdata_next = high_flags;
        end else if (rd_stat) begin
            rdata_next = {14'h0000, stat_reg};
        end else if (rd_mask) begin
            rdata_next = {14'h0000, mask_reg};
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // any newly latched request per register
    always_comb begin
        low_any = |low_new;
        high_any = |high_new;
    end

    // pending status: read clears, a new event in that cycle wins
    always_comb begin
        stat_next = stat_reg;
        if (rd_stat) begin
            stat_next = 2'h0;
        end
        if (low_any) begin
            stat_next[ifs_pkg::STAT_LOW_POS] = 1'b1;
        end
        if (high_any) begin
            stat_next[ifs_pkg::STAT_HIGH_POS] = 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            stat_reg <= ifs_pkg::STAT_RESET;
        end else begin
            stat_reg <= stat_next;
        end
    end

    // interrupt mask, same layout as the pending status
    always_comb begin
        mask_next = mask_reg;
        if (wr_mask) begin
            mask_next = req.wdata[1:0];
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            mask_reg <= ifs_pkg::MASK_RESET;
        end else begin
            mask_reg <= mask_next;
        end
    end

    // level interrupt: high while an unmasked status bit is set
    always_comb begin
        pend_unmasked = stat_next & mask_next;
        irq_next = |pend_unmasked;
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // low flag copy on the pins, one edge behind
    always_comb begin
        out_low_next = low_flags;
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            out_low_reg <= ifs_pkg::FLAGS_RESET;
        end else begin
            out_low_reg <= out_low_next;
        end
    end

    // high flag copy on the pins, one edge behind
    always_comb begin
        out_high_next = high_flags;
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            out_high_reg <= ifs_pkg::FLAGS_RESET;
        end else begin
            out_high_reg <= out_high_next;
        end
    end

    assign RDATA = rdata_reg;
    assign FLAGS_LOW = out_low_reg;
    assign FLAGS_HIGH = out_high_reg;
    assign IRQ = irq_reg;
endmodule // ifs_interrupt_flags

`default_nettype wire

// ---- verif/ifs_flags_props.sv ----
// checker: flag register port relations
`timescale 1ns/100ps
`default_nettype none
module ifs_flags_props (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic EXT_PIN_ZERO_EV,
    input wire logic CHANGE_NOTIFY_EV,
    input wire logic [15:0] RDATA,
    input wire logic [15:0] FLAGS_LOW,
    input wire logic [15:0] FLAGS_HIGH
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);
    logic wr_low;
    assign wr_low = WR && ADDR == ifs_pkg::OFF_FLAGS_LOW;
    a_low_unimpl_zero: assert property ((FLAGS_LOW & ~ifs_pkg::LOW_IMPL_MASK) == 16'h0000)
        else $error("unimplemented low bit set");
    a_high_unimpl_zero: assert property ((FLAGS_HIGH & ~ifs_pkg::HIGH_IMPL_MASK) == 16'h0000)
        else $error("unimplemented high bit set");
    a_unmapped_reads_zero: assert property (RD && ADDR > 4'h3 |=> RDATA == 16'h0000)
        else $error("unmapped read not zero");
    a_read_low_value: assert property (RD && ADDR == ifs_pkg::OFF_FLAGS_LOW |=> RDATA == FLAGS_LOW)
        else $error("low read differs from flags");
    a_pin_zero_sets: assert property (EXT_PIN_ZERO_EV |-> ##2 FLAGS_LOW[0])
        else $error("pin zero flag not set");
    a_change_sets: assert property (CHANGE_NOTIFY_EV |-> ##2 FLAGS_HIGH[11])
        else $error("change flag not set");
    a_flag_sticky: assert property ($fell(FLAGS_LOW[0]) |-> $past(wr_low && !WDATA[0], 2))
        else $error("flag dropped without clear");
    a_write_takes: assert property (wr_low && !EXT_PIN_ZERO_EV ##1 !wr_low && !EXT_PIN_ZERO_EV
        |=> FLAGS_LOW[0] == $past(WDATA[0], 2)) else $error("write not taken");
    c_clear_race: cover property (wr_low && !WDATA[0] && EXT_PIN_ZERO_EV);
    c_unmapped: cover property (RD && ADDR > 4'h3);
    c_cleared: cover property ($fell(FLAGS_LOW[0]));
endmodule // ifs_flags_props
bind ifs_interrupt_flags ifs_flags_props u_props (.MCLK(MCLK), .NRST(NRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .EXT_PIN_ZERO_EV(EXT_PIN_ZERO_EV),
    .CHANGE_NOTIFY_EV(CHANGE_NOTIFY_EV), .RDATA(RDATA), .FLAGS_LOW(FLAGS_LOW),
    .FLAGS_HIGH(FLAGS_HIGH));
`default_nettype wire

// ---- verif/ifs_event_src.sv ----
// peripheral event source model: one-cycle request pulse on a chosen bit
`timescale 1ns/100ps
`default_nettype none
module ifs_event_src (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic sel_high,
    input wire logic [3:0] idx,
    output logic [15:0] ev_low,
    output logic [15:0] ev_high
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ev_low <= 16'h0000;
            ev_high <= 16'h0000;
        end else begin
            ev_low <= (go && !sel_high) ? 16'h0001 << idx : 16'h0000;
            ev_high <= (go && sel_high) ? 16'h0001 << idx : 16'h0000;
        end
    end
endmodule // ifs_event_src
`default_nettype wire

// ---- verif/tb.sv ----
// testbench: register access, event latching and interrupt summary
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic go = 1'b0;
    logic sel_high = 1'b0;
    logic [3:0] idx = 4'h0;
    logic [15:0] ev_low;
    logic [15:0] ev_high;
    logic [15:0] rdata;
    logic [15:0] flags_low;
    logic [15:0] flags_high;
    logic [15:0] msk;
    logic irq;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    always #20 mclk = ~mclk;
    ifs_event_src u_src (.clk(mclk), .rst_n(nrst), .go(go), .sel_high(sel_high), .idx(idx),
        .ev_low(ev_low), .ev_high(ev_high));
    ifs_interrupt_flags u_dut (.MCLK(mclk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .FLAGS_LOW(flags_low), .FLAGS_HIGH(flags_high), .IRQ(irq),
        .TWOWIRE_MASTER_EV(ev_low[ifs_pkg::POS_TWOWIRE_MASTER]),
        .TWOWIRE_SLAVE_EV(ev_low[ifs_pkg::POS_TWOWIRE_SLAVE]),
        .NONVOLATILE_EV(ev_low[ifs_pkg::POS_NONVOLATILE]),
        .CONVERSION_DONE_EV(ev_low[ifs_pkg::POS_CONVERSION_DONE]),
        .SERIAL_TX_EV(ev_low[ifs_pkg::POS_SERIAL_TX]),
        .SERIAL_RX_EV(ev_low[ifs_pkg::POS_SERIAL_RX]),
        .SYNC_SERIAL_EV(ev_low[ifs_pkg::POS_SYNC_SERIAL]),
        .THIRD_TIMER_EV(ev_low[ifs_pkg::POS_THIRD_TIMER]),
        .SECOND_TIMER_EV(ev_low[ifs_pkg::POS_SECOND_TIMER]),
        .COMPARE_TWO_EV(ev_low[ifs_pkg::POS_COMPARE_TWO]),
        .FIRST_TIMER_EV(ev_low[ifs_pkg::POS_FIRST_TIMER]),
        .COMPARE_ONE_EV(ev_low[ifs_pkg::POS_COMPARE_ONE]),
        .CAPTURE_ONE_EV(ev_low[ifs_pkg::POS_CAPTURE_ONE]),
        .EXT_PIN_ZERO_EV(ev_low[ifs_pkg::POS_EXT_PIN_ZERO]),
        .COMPARATOR_THREE_EV(ev_high[ifs_pkg::POS_COMPARATOR_THREE]),
        .COMPARATOR_TWO_EV(ev_high[ifs_pkg::POS_COMPARATOR_TWO]),
        .COMPARATOR_ONE_EV(ev_high[ifs_pkg::POS_COMPARATOR_ONE]),
        .CHANGE_NOTIFY_EV(ev_high[ifs_pkg::POS_CHANGE_NOTIFY]),
        .PULSE_GEN_FOUR_EV(ev_high[ifs_pkg::POS_PULSE_GEN_FOUR]),
        .PULSE_GEN_THREE_EV(ev_high[ifs_pkg::POS_PULSE_GEN_THREE]),
        .PULSE_GEN_TWO_EV(ev_high[ifs_pkg::POS_PULSE_GEN_TWO]),
        .PULSE_GEN_ONE_EV(ev_high[ifs_pkg::POS_PULSE_GEN_ONE]),
        .SPECIAL_EVENT_EV(ev_high[ifs_pkg::POS_SPECIAL_EVENT]),
        .EXT_PIN_TWO_EV(ev_high[ifs_pkg::POS_EXT_PIN_TWO]),
        .EXT_PIN_ONE_EV(ev_high[ifs_pkg::POS_EXT_PIN_ONE]));
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    // request reaches the block at the last edge of this task
    task automatic fire(input logic h, input logic [3:0] i);
        @(posedge mclk);
        go <= 1'b1;
        sel_high <= h;
        idx <= i;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        rd_reg(ifs_pkg::OFF_FLAGS_LOW, ifs_pkg::FLAGS_RESET);
        rd_reg(ifs_pkg::OFF_FLAGS_HIGH, ifs_pkg::FLAGS_RESET);
        wr_reg(ifs_pkg::OFF_FLAGS_LOW, 16'hffff);
        wr_reg(ifs_pkg::OFF_FLAGS_HIGH, 16'hffff);
        rd_reg(ifs_pkg::OFF_FLAGS_LOW, ifs_pkg::LOW_IMPL_MASK);
        rd_reg(ifs_pkg::OFF_FLAGS_HIGH, ifs_pkg::HIGH_IMPL_MASK);
        chk(flags_high, ifs_pkg::HIGH_IMPL_MASK);
        wr_reg(ifs_pkg::OFF_FLAGS_LOW, 16'h0000);
        wr_reg(ifs_pkg::OFF_FLAGS_HIGH, 16'h0000);
        rd_reg(ifs_pkg::OFF_FLAGS_HIGH, 16'h0000);
        wr_reg(4'h9, 16'hffff);
        rd_reg(4'h9, 16'h0000);
        for (int h = 0; h < 2; h++) begin
            msk = h ? ifs_pkg::HIGH_IMPL_MASK : ifs_pkg::LOW_IMPL_MASK;
            for (int i = 0; i < 16; i++) begin
                if (msk[i]) begin
                    fire(h[0], i[3:0]);
                    rd_reg(h[3:0], 16'h0001 << i);
                    chk(h ? flags_high : flags_low, 16'h0001 << i);
                    wr_reg(h[3:0], 16'h0000);
                    rd_reg(h[3:0], 16'h0000);
                end
            end
        end
        rd_reg(ifs_pkg::OFF_PEND_STAT, 16'h0003);
        wr_reg(ifs_pkg::OFF_PEND_MASK, 16'h0001);
        fire(1'b0, 4'h0);
        repeat (2) @(posedge mclk);
        #1;
        chk({15'h0000, irq}, 16'h0001);
        rd_reg(ifs_pkg::OFF_PEND_STAT, 16'h0001);
        chk({15'h0000, irq}, 16'h0000);
        fire(1'b1, 4'h0);
        repeat (2) @(posedge mclk);
        #1;
        chk({15'h0000, irq}, 16'h0000);
        rd_reg(ifs_pkg::OFF_PEND_STAT, 16'h0002);
        wr_reg(ifs_pkg::OFF_PEND_STAT, 16'hffff);
        rd_reg(ifs_pkg::OFF_PEND_STAT, 16'h0000);
        rd_reg(ifs_pkg::OFF_PEND_MASK, 16'h0001);
        wr_reg(ifs_pkg::OFF_FLAGS_LOW, 16'h0000);
        // clear and request meet at one edge
        @(posedge mclk);
        go <= 1'b1;
        sel_high <= 1'b0;
        idx <= 4'h0;
        @(posedge mclk);
        go <= 1'b0;
        wr <= 1'b1;
        addr <= ifs_pkg::OFF_FLAGS_LOW;
        wdata <= 16'h0000;
        @(posedge mclk);
        wr <= 1'b0;
        rd_reg(ifs_pkg::OFF_FLAGS_LOW, 16'h0001);
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        rd_reg(ifs_pkg::OFF_FLAGS_LOW, ifs_pkg::FLAGS_RESET);
        chk(flags_high, ifs_pkg::FLAGS_RESET);
        rd_reg(ifs_pkg::OFF_PEND_MASK, 16'h0000);
        final_report();
    end
endmodule // tb
`default_nettype wire
